/* File: rtl/sfid_decoder.v */
// Purpose: instruction front end of a serial flash
// Assumes: pins sampled by clk, link clock far slower than clk
// Notes:   queue carries opcode, bytes and a commit or abort word
`include "sfid_defines.vh"

// ----------------------------------------
// Queue toward the array side
// ----------------------------------------
module sfid_fifo #(
	parameter W  = 18,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire         clk,
	input  wire         reset_n,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1]; // Flop storage
	reg [AW-1:0] wp;         // Write index
	reg [AW-1:0] rp;         // Read index
	reg [AW:0]   cnt;        // Fill level
	wire         wr = in_valid && in_ready;
	wire         rd = out_valid && out_ready;
	assign in_ready  = (cnt != D[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data  = mem[rp];
	// Storage write
	always @(posedge clk) begin
		if (wr) begin
			mem[wp] <= in_data;
		end
	end
	// Pointers and level
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp  <= {AW{1'b0}};
			rp  <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (wr) wp <= wp + 1'b1;
			if (rd) rp <= rp + 1'b1;
			cnt <= cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
		end
	end
endmodule

// ----------------------------------------
// Decoder top
// ----------------------------------------
module sfid_decoder #(
	parameter [7:0] MAKER    = 8'h5A, // Arbitrary value
	parameter [7:0] DEVICE   = 8'h3C, // Arbitrary value
	parameter [7:0] TYPE_ONE = 8'h41, // Arbitrary value
	parameter [7:0] TYPE_FOUR= 8'h42, // Arbitrary value
	parameter [7:0] CAPACITY = 8'h24, // Arbitrary value
	parameter       DEPTH    = 16
) (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        cs_n,
	input  wire        sck,
	input  wire [3:0]  io_in,
	output reg  [3:0]  io_out,
	output reg  [3:0]  io_oe_n,
	input  wire        busy,
	input  wire        addr_protected,
	input  wire [7:0]  status_low_byte,
	input  wire [7:0]  status_high_byte,
	input  wire [7:0]  rd_data,
	output reg  [23:0] cmd_addr,
	output reg  [23:0] rd_addr,
	output reg  [7:0]  continuous_mode_bits,
	output reg  [7:0]  read_parameter_byte,
	output reg         wel,
	output reg         vol_sr_en,
	output reg         power_down,
	output reg         four_line_command_mode,
	output reg         suspend_pulse,
	output reg         resume_pulse,
	output wire        q_valid,
	input  wire        q_ready,
	output wire [17:0] q_data
);
	localparam [5:0] S_IDLE = 6'h01, S_CMD = 6'h02, S_ADDR = 6'h04;
	localparam [5:0] S_DUM  = 6'h08, S_OUT = 6'h10, S_IGN  = 6'h20;
	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	reg  [5:0] sy1, sy2;        // Two-stage sync
	reg        sck_d, cs_d;     // Previous levels
	wire       cs_l  = sy2[5];
	wire [3:0] io_s  = sy2[3:0];
	wire       rise  = sy2[4] & ~sck_d & ~cs_l;
	wire       fall  = ~sy2[4] & sck_d & ~cs_l;
	wire       cs_fl = ~cs_l & cs_d;
	wire       cs_rs = cs_l & ~cs_d;
	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	reg [5:0]  state;
	reg [7:0]  op, ish, osh, obyte, dcol;
	reg [3:0]  icnt, ocnt, dcnt, dum;
	reg [2:0]  bidx, nin, aw, dw, ow;
	reg [1:0]  jidx;            // Identity triple index
	reg        pay, wr, prot, bad, dseen;
	reg        push_v, push_end;
	reg [17:0] push_w;
	reg        pend;            // End word waiting
	reg [1:0]  pend_k;
	wire       q_in_ready;
	// Lines per bit time while shifting in
	wire [2:0] aq   = four_line_command_mode ? `W4 : `W1;
	wire [2:0] w_in = (state == S_CMD) ? aq : ((bidx < nin) ? aw : dw);
	wire [3:0] icnt_n = icnt + {1'b0, w_in};
	wire       bdone  = (icnt_n == `BYTE_BITS);
	wire [7:0] nsh = (w_in == `W4) ? {ish[3:0], io_s} :
		(w_in == `W2) ? {ish[5:0], io_s[1:0]} : {ish[6:0], io_s[0]};
	// ----------------------------------------
	// Opcode decode
	// ----------------------------------------
	reg [2:0] d_nin, d_aw, d_dw, d_ow;
	reg [3:0] d_dum;
	reg       d_pay, d_wr, d_prot, d_ok;
	always @* begin
		d_nin = 3'h0; d_aw = aq; d_dw = aq; d_ow = 3'h0; d_dum = 4'h0;
		d_pay = 1'b0; d_wr = 1'b0; d_prot = 1'b0; d_ok = 1'b1;
		case (nsh)
			`OP_WREN, `OP_VSRWE, `OP_WRDI, `OP_SUSP, `OP_RESUME,
			`OP_PD, `OP_QON, `OP_QOFF: d_ok = 1'b1;
			`OP_RDSR1, `OP_RDSR2: d_ow = aq;
			`OP_WRSR: begin
				d_pay = 1'b1;
				d_wr  = 1'b1;
			end
			`OP_SRP: d_pay = 1'b1;
			`OP_PP, `OP_PSR, `OP_QPP: begin
				d_nin = `N_ADDR; d_pay = 1'b1; d_wr = 1'b1; d_prot = 1'b1;
				if (nsh == `OP_QPP) d_dw = `W4;
			end
			`OP_SE, `OP_BE32, `OP_BE64, `OP_ESR: begin
				d_nin = `N_ADDR; d_wr = 1'b1; d_prot = 1'b1;
			end
			`OP_CE1, `OP_CE2: begin
				d_wr = 1'b1; d_prot = 1'b1;
			end
			`OP_WAKE: begin
				d_nin = `N_WAKE; d_ow = aq;
			end
			`OP_JID: d_ow = aq;
			`OP_DID: begin
				d_nin = `N_ADDRM; d_aw = `W2; d_ow = `W2;
			end
			`OP_QID: begin
				d_nin = `N_ADDRM; d_aw = `W4; d_ow = `W4; d_dum = `DUM_QID;
			end
			`OP_WQR, `OP_QIOR: begin
				d_nin = `N_ADDRM; d_aw = `W4; d_ow = `W4;
				d_dum = (nsh == `OP_WQR) ? `DUM_WQR : `DUM_QIOR;
				if (four_line_command_mode) d_dum = read_parameter_byte[7:4];
			end
			`OP_READ: begin
				d_nin = `N_ADDR; d_ow = aq;
			end
			`OP_FAST, `OP_WRAP: begin
				d_nin = `N_ADDR; d_ow = aq;
				d_dum = four_line_command_mode ? read_parameter_byte[7:4] : `DUM_FAST;
				if (!four_line_command_mode && nsh == `OP_WRAP) d_ok = 1'b0;
			end
			default: d_ok = 1'b0;
		endcase
	end
	// Byte to send next
	reg [7:0] nb;
	always @* begin
		case (op)
			`OP_JID: nb = (jidx == 2'h0) ? MAKER : (jidx == 2'h1) ?
				(four_line_command_mode ? TYPE_FOUR : TYPE_ONE) : CAPACITY;
			`OP_WAKE: nb = DEVICE;
			`OP_DID, `OP_QID: nb = obyte[0] ? DEVICE : MAKER;
			`OP_RDSR1: nb = status_low_byte;
			`OP_RDSR2: nb = status_high_byte;
			default: nb = rd_data;
		endcase
	end
	// End-of-frame verdict for write types
	wire end_ok = (icnt == 4'h0) && !bad && wel && (bidx >= nin) &&
		!(prot && addr_protected) && (!pay || dseen || op == `OP_WRSR);
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sy1 <= 6'h30; sy2 <= 6'h30; sck_d <= 1'b1; cs_d <= 1'b1;
			state <= S_IDLE; op <= 8'h00; ish <= 8'h00; osh <= 8'h00;
			obyte <= 8'h00; dcol <= 8'h00; icnt <= 4'h0; ocnt <= 4'h0;
			dcnt <= 4'h0; dum <= 4'h0; bidx <= 3'h0; nin <= 3'h0;
			aw <= `W1; dw <= `W1; ow <= 3'h0; jidx <= 2'h0;
			pay <= 1'b0; wr <= 1'b0; prot <= 1'b0; bad <= 1'b0;
			dseen <= 1'b0; push_v <= 1'b0; push_end <= 1'b0;
			push_w <= 18'h00000; pend <= 1'b0; pend_k <= `K_OK;
			io_out <= 4'h0; io_oe_n <= `OE_OFF; cmd_addr <= 24'h000000;
			rd_addr <= 24'h000000; continuous_mode_bits <= 8'h00;
			read_parameter_byte <= `RP_RESET; wel <= 1'b0; vol_sr_en <= 1'b0;
			power_down <= 1'b0; four_line_command_mode <= 1'b0;
			suspend_pulse <= 1'b0; resume_pulse <= 1'b0;
		end else begin
			sy1 <= {cs_n, sck, io_in};
			sy2 <= sy1;
			sck_d <= sy2[4];
			cs_d <= cs_l;
			suspend_pulse <= 1'b0;
			resume_pulse <= 1'b0;
			// Queue handshake; a lost byte spoils the frame
			if (push_v && q_in_ready) begin
				push_v <= 1'b0;
			end else if (push_v && !push_end) begin
				push_v <= 1'b0;
				bad <= 1'b1;
			end else if (!push_v && pend) begin
				push_v <= 1'b1; push_end <= 1'b1; pend <= 1'b0;
				push_w <= {pend_k, op, 8'h00};
			end
			if (cs_fl) begin
				state <= S_CMD; icnt <= 4'h0; bidx <= 3'h0; bad <= 1'b0;
				dseen <= 1'b0; wr <= 1'b0; dcnt <= 4'h0; ocnt <= 4'h0;
				obyte <= 8'h00; jidx <= 2'h0; ish <= 8'h00;
			end else if (cs_rs) begin
				state <= S_IDLE;
				io_oe_n <= `OE_OFF;
				if (wr) begin
					pend <= 1'b1;
					pend_k <= end_ok ? `K_OK : `K_BAD;
				end
			end else if (rise && (state == S_CMD || state == S_ADDR)) begin
				ish <= nsh;
				icnt <= bdone ? 4'h0 : icnt_n;
				if (bdone && state == S_CMD) begin
					op <= nsh; nin <= d_nin; aw <= d_aw; dw <= d_dw; ow <= d_ow;
					dum <= d_dum; pay <= d_pay; wr <= 1'b0; prot <= d_prot;
					if (!d_ok || (busy && nsh != `OP_RDSR1 && nsh != `OP_RDSR2) ||
						(power_down && nsh != `OP_WAKE)) begin
						state <= S_IGN;
					end else begin
						state <= (d_nin == 3'h0 && d_ow != 3'h0) ? S_OUT : S_ADDR;
						wr <= d_wr;
						if (d_wr) begin
							push_v <= 1'b1; push_end <= 1'b0;
							push_w <= {`K_OPC, nsh, 8'h00};
						end
						case (nsh)
							`OP_WREN:   wel <= 1'b1;
							`OP_WRDI:   wel <= 1'b0;
							`OP_VSRWE:  vol_sr_en <= 1'b1;
							`OP_SUSP:   suspend_pulse <= 1'b1;
							`OP_RESUME: resume_pulse <= 1'b1;
							`OP_PD:     power_down <= 1'b1;
							`OP_WAKE:   power_down <= 1'b0;
							`OP_QON:    four_line_command_mode <= 1'b1;
							`OP_QOFF:   four_line_command_mode <= 1'b0;
							default:    wel <= wel;
						endcase
					end
				end else if (bdone) begin
					if (bidx < nin) begin
						bidx <= bidx + 3'h1;
						if (bidx < `N_ADDR) cmd_addr <= {cmd_addr[15:0], nsh};
						else continuous_mode_bits <= nsh;
						if (bidx == `N_ADDR - 3'h1) dcol <= nsh;
						if (bidx == `N_ADDR - 3'h1) rd_addr <= {cmd_addr[15:0], nsh};
						if (wr) begin
							push_v <= 1'b1; push_end <= 1'b0;
							push_w <= {`K_BYTE, {5'h00, bidx}, nsh};
						end
						if (bidx + 3'h1 == nin && ow != 3'h0) begin
							state <= (dum != 4'h0) ? S_DUM : S_OUT;
						end
					end else if (pay) begin
						dseen <= 1'b1;
						dcol <= dcol + 8'h01;
						if (op == `OP_SRP) read_parameter_byte <= nsh;
						if (wr) begin
							push_v <= 1'b1; push_end <= 1'b0;
							push_w <= {`K_BYTE, dcol, nsh};
						end
					end
				end
			end else if (rise && state == S_DUM) begin
				dcnt <= dcnt + 4'h1;
				if (dcnt + 4'h1 == dum) state <= S_OUT;
			end else if (fall && state == S_OUT) begin
				if (ocnt == 4'h0) begin
					obyte <= obyte + 8'h01;
					jidx <= (jidx == 2'h2) ? 2'h0 : jidx + 2'h1;
					if (op != `OP_JID && op != `OP_WAKE && op != `OP_DID &&
						op != `OP_QID && op != `OP_RDSR1 && op != `OP_RDSR2) begin
						rd_addr <= rd_addr + 24'h000001;
					end
				end
				osh <= ((ocnt == 4'h0) ? nb : osh) << ow;
				ocnt <= (ocnt + {1'b0, ow} == `BYTE_BITS) ? 4'h0 : ocnt + {1'b0, ow};
				if (ow == `W4) begin
					io_out <= ((ocnt == 4'h0) ? nb[7:4] : osh[7:4]);
					io_oe_n <= `OE_W4;
				end else if (ow == `W2) begin
					io_out <= {2'h0, ((ocnt == 4'h0) ? nb[7:6] : osh[7:6])};
					io_oe_n <= `OE_W2;
				end else begin
					io_out <= {2'h0, ((ocnt == 4'h0) ? nb[7] : osh[7]), 1'b0};
					io_oe_n <= `OE_W1;
				end
			end
		end
	end
	// ----------------------------------------
	// Queue instance
	// ----------------------------------------
	sfid_fifo #(.W(18), .D(DEPTH), .AW(4)) u_q (
		.clk      (clk),
		.reset_n  (reset_n),
		.in_valid (push_v),
		.in_ready (q_in_ready),
		.in_data  (push_w),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data (q_data)
	);
endmodule

/* File: shared/sfid_defines.vh */
// Purpose: constants of the serial flash instruction decoder
// Assumes: single, dual and four-line framing on the serial pins
// Notes:   opcodes, widths, dummy counts and queue word kinds
// How it works
// - select falling starts a new frame
// - single line: opcode on serial_in_line, MSB first
// - four-line mode: four lines, high nibble first
// - four-line mode: every byte takes two clocks, except 92h bytes (two-line, four clocks)
// - select rising ends the frame
// - reads may end after any bit
// - writes ending mid-byte are discarded
// - busy: only status reads accepted
// - protected target erase/program ignored
// - 06h/50h/04h write-control opcodes decoded
// - 75h suspends, 7Ah resumes
// - ABh wakes; three dummies then device byte
// - 92h: two-line address, two-line identity
// - 94h: four-line address, dummies, repeating identity
// - E7h: four-line address, short dummy, data
// - 9Fh: maker, type, capacity; type per mode
// - page data wraps within 256 bytes
// - status and identity bytes repeat
// - four-line read dummies from upper parameter nibble
`ifndef SFID_DEFINES_VH
`define SFID_DEFINES_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_WREN   8'h06
`define OP_VSRWE  8'h50
`define OP_WRDI   8'h04
`define OP_RDSR1  8'h05
`define OP_RDSR2  8'h35
`define OP_WRSR   8'h01
`define OP_PP     8'h02
`define OP_QPP    8'h32
`define OP_PSR    8'h42
`define OP_ESR    8'h44
`define OP_SE     8'h20
`define OP_BE32   8'h52
`define OP_BE64   8'hD8
`define OP_CE1    8'hC7
`define OP_CE2    8'h60
`define OP_SUSP   8'h75
`define OP_RESUME 8'h7A
`define OP_PD     8'hB9
`define OP_WAKE   8'hAB
`define OP_JID    8'h9F
`define OP_DID    8'h92
`define OP_QID    8'h94
`define OP_WQR    8'hE7
`define OP_QIOR   8'hEB
`define OP_READ   8'h03
`define OP_FAST   8'h0B
`define OP_WRAP   8'h0C
`define OP_SRP    8'hC0
`define OP_QON    8'h38
`define OP_QOFF   8'hFF
// ----------------------------------------
// Widths, counts and queue word kinds
// ----------------------------------------
`define W1        3'h1
`define W2        3'h2
`define W4        3'h4
`define BYTE_BITS 4'h8
`define N_ADDR    3'h3
`define N_ADDRM   3'h4
`define N_WAKE    3'h3
`define DUM_FAST  4'h8
`define DUM_QID   4'h4
`define DUM_WQR   4'h2
`define DUM_QIOR  4'h4
`define RP_RESET  8'h00
`define K_OPC     2'h0
`define K_BYTE    2'h1
`define K_OK      2'h2
`define K_BAD     2'h3
`define OE_W1     4'hD
`define OE_W2     4'hC
`define OE_W4     4'h0
`define OE_OFF    4'hF
`endif

/* File: verification/sfid_decoder_props.sv */
// Purpose: port assertions of the decoder top
// Assumes: one clock domain, reset_n active low
// Notes:   bound to every decoder instance
module sfid_decoder_props (
	input wire        clk,
	input wire        reset_n,
	input wire        cs_n,
	input wire [3:0]  io_oe_n,
	input wire        busy,
	input wire        wel,
	input wire        power_down,
	input wire        four_line_command_mode,
	input wire        suspend_pulse,
	input wire        resume_pulse,
	input wire        q_valid,
	input wire        q_ready,
	input wire [17:0] q_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Clocking and reset
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Pins released once deselected
	AST_IDLE_RELEASE: assert property (cs_n [*7] |-> io_oe_n == 4'hF)
		else $error("pins driven while deselected");
	// Only width codes on the enables
	AST_OE_CODES: assert property (io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
		else $error("bad enable pattern");
	// Suspend and resume are single pulses
	AST_SUSP_ONE: assert property (suspend_pulse |=> !suspend_pulse)
		else $error("suspend pulse too long");
	AST_RES_ONE: assert property (resume_pulse |=> !resume_pulse)
		else $error("resume pulse too long");
	AST_SUSP_EXCL: assert property (!(suspend_pulse && resume_pulse))
		else $error("suspend and resume together");
	// Latch set only inside a frame
	AST_WEL_FRAME: assert property ($rose(wel) |-> !$past(cs_n, 3))
		else $error("latch set outside a frame");
	// Busy refuses flag changes
	AST_BUSY_WEL: assert property ($rose(wel) |-> !$past(busy))
		else $error("latch set while busy");
	AST_BUSY_MODE: assert property (
		$rose(power_down) || $changed(four_line_command_mode) |-> !$past(busy))
		else $error("mode changed while busy");
	// Queue words stand until taken
	AST_Q_STAND: assert property (q_valid && !q_ready |=> q_valid && $stable(q_data))
		else $error("queue word dropped");
endmodule

bind sfid_decoder sfid_decoder_props i_sfid_decoder_props (
	.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .io_oe_n(io_oe_n), .busy(busy),
	.wel(wel), .power_down(power_down), .four_line_command_mode(four_line_command_mode),
	.suspend_pulse(suspend_pulse), .resume_pulse(resume_pulse),
	.q_valid(q_valid), .q_ready(q_ready), .q_data(q_data));

/* File: verification/sfid_host.sv */
// Purpose: host model driving select, link clock and lines
// Assumes: link clock idles low, runs only within frames
// Notes:   lines it does not drive toggle every link clock
module sfid_host (
	input  wire       clk,
	input  wire [3:0] io_out,
	input  wire [3:0] io_oe_n,
	output logic      cs_n,
	output logic      sck,
	output wire [3:0] io_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] drv;         // Host line values
	logic [7:0] acc;         // Byte being received
	logic       wide = 1'h0; // Four-line framing
	logic [7:0] got [$];     // Bytes received in last frame
	logic [3:0] oe_seen;     // Enables at the last read sample
	// Wire level: an enabled device pin wins
	assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv);
	initial begin
		cs_n = 1'h1;
		sck  = 1'h0;
		drv  = 4'h0;
	end
	// Frame: bytes out, nrx bytes in, cut bits dropped
	task automatic frame(input logic [7:0] tx [$], input int cut, input int nrx);
		logic [7:0] sh;
		int         w;
		int         nb;
		w  = wide ? 4 : 1;
		nb = 8 * (tx.size() + nrx) - cut;
		got = {};
		oe_seen = 4'hF;
		@(negedge clk);
		cs_n = 1'h0;
		for (int i = 0; i < nb; i += w) begin
			sh = (i < 8 * tx.size()) ? tx[i / 8] << (i % 8) : 8'h00;
			if (i < 8 * tx.size())
				drv = wide ? sh[7:4] : {~drv[3:1], sh[7]};
			else
				drv = ~drv;
			repeat (4) @(negedge clk);
			sck = 1'h1;
			repeat (4) @(negedge clk);
			acc = wide ? {acc[3:0], io_in} : {acc[6:0], io_in[1]};
			if (i >= 8 * tx.size())
				oe_seen = io_oe_n;
			if (i >= 8 * tx.size() && (i + w) % 8 == 0)
				got.push_back(acc);
			sck = 1'h0;
		end
		drv = ~drv;
		repeat (4) @(negedge clk);
		cs_n = 1'h1;
		repeat (8) @(negedge clk);
	endtask
endmodule

/* File: verification/sfid_decoder_tb_top.sv */
// Purpose: self-checking bench of the instruction decoder
// Assumes: host model frames, bench drives the rest
// Notes:   queue words checked by a watcher process
`include "sfid_defines.vh"
`define CHK(a, b) begin \
	compares++; \
	if ((a) !== (b)) begin \
		errors++; \
		$display("Error at %0t: got %h expected %h", $time, (a), (b)); \
	end \
end
module sfid_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [7:0] MK = 8'h5A, DV = 8'h3C, T1 = 8'h41, T4 = 8'h42, CP = 8'h24;
	logic        clk, reset_n, busy, addr_protected, q_ready, q_valid, stall;
	logic        cs_n, sck, wel, vol_sr_en, power_down, four_line_command_mode;
	logic        suspend_pulse, resume_pulse;
	logic [3:0]  io_in, io_out, io_oe_n;
	logic [7:0]  status_low_byte, status_high_byte, rd_data;
	logic [17:0] q_data;
	logic [23:0] cmd_addr, rd_addr;
	logic [7:0]  read_parameter_byte;
	logic [31:0] r, rn;      // Random draws
	logic [35:0] expq [$];   // Expected words {mask, value}
	logic [7:0]  tx [$];     // Bytes of the next frame
	int          errors = 0, compares = 0, nsus = 0, nres = 0, seed;
	sfid_host i_sfid_host (.clk(clk), .io_out(io_out), .io_oe_n(io_oe_n),
		.cs_n(cs_n), .sck(sck), .io_in(io_in));
	sfid_decoder #(.MAKER(MK), .DEVICE(DV), .TYPE_ONE(T1), .TYPE_FOUR(T4),
		.CAPACITY(CP), .DEPTH(16)) i_sfid_decoder (.clk(clk), .reset_n(reset_n),
		.cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
		.busy(busy), .addr_protected(addr_protected), .status_low_byte(status_low_byte),
		.status_high_byte(status_high_byte), .rd_data(rd_data), .cmd_addr(cmd_addr),
		.rd_addr(rd_addr), .continuous_mode_bits(), .read_parameter_byte(read_parameter_byte),
		.wel(wel), .vol_sr_en(vol_sr_en),
		.power_down(power_down), .four_line_command_mode(four_line_command_mode),
		.suspend_pulse(suspend_pulse), .resume_pulse(resume_pulse),
		.q_valid(q_valid), .q_ready(q_ready), .q_data(q_data));
	// Clock, 40 ns
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	// Random queue stalls and array data
	always @(negedge clk) begin
		rn = $random(seed);
		q_ready <= !stall && rn[0];
		rd_data <= rd_addr[7:0] ^ 8'h5A; // Array model: data follows address
	end
	// Watcher: oldest note against each taken word
	always @(posedge clk) begin
		if (reset_n && q_valid === 1'h1 && q_ready) begin
			if (expq.size() > 0) begin
				`CHK(q_data & expq[0][35:18], expq[0][17:0])
				void'(expq.pop_front());
			end else begin
				`CHK(expq.size(), 1)
			end
		end
		nsus <= nsus + suspend_pulse;
		nres <= nres + resume_pulse;
	end
	// Note one expected word; m: 0 kind, 1 plus column, 2 all
	task automatic ex(input [1:0] k, input [7:0] c, input [7:0] v, input int m);
		logic [7:0] mc, md;
		mc = (m > 0) ? 8'hFF : 8'h00;
		md = (m > 1) ? 8'hFF : 8'h00;
		expq.push_back({2'h3, mc, md, k, c & mc, v & md});
	endtask
	// Page program at 1234FEh, n data bytes
	task automatic prog(input int n, input int cut, input logic prot);
		int ok, kept;
		ok = (cut == 0) && !prot && (n < 13);
		kept = (n < 13) ? n - (cut > 0) : 12;
		tx = {`OP_PP, 8'h12, 8'h34, 8'hFE};
		ex(`K_OPC, `OP_PP, 8'h00, 1);
		for (int i = 0; i < 3; i++)
			ex(`K_BYTE, i[7:0], tx[i + 1], 2);
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			tx.push_back(r[7:0]);
			if (i < kept)
				ex(`K_BYTE, 8'hFE + i[7:0], r[7:0], 2);
		end
		ex(ok ? `K_OK : `K_BAD, `OP_PP, 8'h00, 1);
		addr_protected = prot;
		i_sfid_host.frame(tx, cut, 0);
		stall = 1'h0;
		for (int i = 0; i < 400 && expq.size() > 0; i++)
			@(negedge clk);
		`CHK(expq.size(), 0)
		addr_protected = 1'h0;
	endtask
	task automatic op(input logic [7:0] o, input int nrx);
		tx = {o};
		i_sfid_host.frame(tx, 0, nrx);
	endtask
	// Received bytes against a list
	task automatic rd(input logic [7:0] e [$]);
		foreach (e[i])
			`CHK(i_sfid_host.got[i], e[i])
	endtask
	task automatic end_of_test;
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		end_of_test;
	end
	// Main sequence
	initial begin
		seed = 32'h68b8887d;
		{reset_n, busy, addr_protected, stall, q_ready} = 5'h00;
		{status_low_byte, status_high_byte, rd_data} = 24'h000000;
		repeat (10) @(negedge clk);
		reset_n = 1'h1;
		repeat (4) @(negedge clk);
		op(`OP_WREN, 0);
		`CHK(wel, 1'h1)
		op(`OP_VSRWE, 0);
		`CHK(vol_sr_en, 1'h1)
		prog(3, 0, 1'h0);
		`CHK(cmd_addr, 24'h1234FE)
		prog(1, 3, 1'h0);
		prog(1, 0, 1'h1);
		stall = 1'h1;
		prog(14, 0, 1'h0);
		op(`OP_SUSP, 0);
		op(`OP_RESUME, 0);
		`CHK(nsus, 1)
		`CHK(nres, 1)
		op(`OP_WRDI, 0);
		`CHK(wel, 1'h0)
		busy = 1'h1;
		r = $random(seed);
		status_low_byte = r[7:0];
		op(`OP_WREN, 0);
		`CHK(wel, 1'h0)
		op(`OP_RDSR1, 2);
		rd({r[7:0], r[7:0]});
		`CHK(i_sfid_host.oe_seen, `OE_W1)
		busy = 1'h0;
		op(`OP_JID, 4);
		rd({MK, T1, CP, MK});
		op(`OP_PD, 0);
		`CHK(power_down, 1'h1)
		tx = {`OP_WAKE, 8'h00, 8'h00, 8'h00};
		i_sfid_host.frame(tx, 0, 2);
		rd({DV, DV});
		`CHK(power_down, 1'h0)
		tx = {`OP_SRP, 8'h30};
		i_sfid_host.frame(tx, 0, 0);
		`CHK(read_parameter_byte, 8'h30)
		op(`OP_QON, 0);
		`CHK(four_line_command_mode, 1'h1)
		i_sfid_host.wide = 1'h1;
		op(`OP_WREN, 0);
		`CHK(wel, 1'h1)
		op(`OP_JID, 3);
		rd({MK, T4, CP});
		`CHK(i_sfid_host.oe_seen, `OE_W4)
		op(`OP_QOFF, 0);
		`CHK(four_line_command_mode, 1'h0)
		i_sfid_host.wide = 1'h0;
		// Plain read, then the same read cut inside its second data byte
		tx = {`OP_READ, 8'h00, 8'h00, 8'hFE};
		i_sfid_host.frame(tx, 0, 2);
		rd({8'hFE ^ 8'h5A, 8'hFF ^ 8'h5A});
		i_sfid_host.frame(tx, 3, 2);
		rd({8'hFE ^ 8'h5A});
		op(8'h11, 1);
		`CHK(wel, 1'h1)
		`CHK(i_sfid_host.oe_seen, `OE_OFF)
		end_of_test;
	end
endmodule
